// [design/lfse_pkg.sv]
package lfse_pkg;
    // program store and device map sizes
    localparam int PROG_DEPTH = 256;
    localparam int ADDR_W = 8;
    localparam int BIT_DEVS = 64;
    localparam int X_PINS = 16;
    localparam int NUM_TMR = 8;
    localparam int NUM_CNT = 8;
    localparam int PV_W = 8;
    localparam int NEST_LEVELS = 15;

    // contact address windows: bit devices, then timer contacts, then counter contacts
    localparam logic [7:0] TMR_BASE = 8'h40;
    localparam logic [7:0] CNT_BASE = 8'h48;
    localparam logic [7:0] DEV_LIMIT = 8'h50;

    // instruction fields: [15:12] opcode, [11:8] nest or setting, [7:0] operand
    localparam int OP_POS = 12;
    localparam int AUX_POS = 8;
    localparam int RETAIN_BIT = 7;

    // opcodes
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_LOAD = 4'h1;
    localparam logic [3:0] OP_LOAD_INV = 4'h2;
    localparam logic [3:0] OP_AND = 4'h3;
    localparam logic [3:0] OP_OR = 4'h4;
    localparam logic [3:0] OP_COIL = 4'h5;
    localparam logic [3:0] OP_SET = 4'h6;
    localparam logic [3:0] OP_CLEAR = 4'h7;
    localparam logic [3:0] OP_SHIFT = 4'h8;
    localparam logic [3:0] OP_SHIFT_PULSED = 4'h9;
    localparam logic [3:0] OP_GATE_OPEN = 4'ha;
    localparam logic [3:0] OP_GATE_CLOSE = 4'hb;
    localparam logic [3:0] OP_TIMER = 4'hc;
    localparam logic [3:0] OP_COUNTER = 4'hd;
    localparam logic [3:0] OP_MAIN_TERM = 4'he;
    localparam logic [3:0] OP_PROG_END = 4'hf;

    // timer base period
    localparam int TICK_MS = 10;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TICK_W = 21;

    // reset values
    localparam logic [ADDR_W-1:0] PC_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_CHECK,
        ST_RUN,
        ST_ERROR
    } lfse_state_t;

    typedef struct packed {
        lfse_state_t state;
        logic [ADDR_W-1:0] pc;
        logic acc;
        logic [BIT_DEVS-1:0] bits;
        logic [NUM_TMR-1:0][PV_W-1:0] tmrPv;
        logic [NUM_TMR-1:0] tmrCoil;
        logic [NUM_TMR-1:0] tmrDone;
        logic [NUM_CNT-1:0][PV_W-1:0] cntPv;
        logic [NUM_CNT-1:0] cntCoil;
        logic [NUM_CNT-1:0] cntDone;
        logic [NEST_LEVELS-1:0] gateOpen;
        logic [NEST_LEVELS-1:0] gateOn;
        logic [PROG_DEPTH-1:0] pulseMem;
        logic [TICK_W-1:0] tickCnt;
        logic tickSeen;
        logic tickScan;
        logic [X_PINS-1:0] xSync1;
        logic [X_PINS-1:0] xSync2;
        logic opError;
        logic scanDone;
        logic runFlag; // run status kept in a flop so the output needs no decode
    } lfse_regs_t;
endpackage

// [design/ladder_flow_shift_engine.sv]
// Overview of operation
// - shift moves lower device into target, clearing the lower one
// - enabled region evaluates instructions normally
// - disabled region still steps every instruction
// - disabled plain timer cleared, coil contact off
// - disabled retentive timer/counter coil off only
// - disabled region forces plain coils off
// - disabled region keeps set/clear/shift devices
// - same nesting number reusable, different gate
// - gate device coil follows open condition
// - fifteen nesting levels, numbers zero-fourteen
// - one low close ends all inner regions
// - main terminate ends the scan there
// - program end wraps to step zero
// - missing end raises error, no run
`timescale 1ns/10ps
`default_nettype none
module lfse_ladder_flow_shift_engine #(
    parameter int TICK_CYCLES = lfse_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // program load port, same clock domain
    input wire logic progWe,
    input wire logic [lfse_pkg::ADDR_W-1:0] progAddr,
    input wire logic [15:0] progData,
    // run request, same clock domain
    input wire logic runEn,
    // external input pins, asynchronous
    input wire logic [lfse_pkg::X_PINS-1:0] xPins,
    // device image and status
    output logic [lfse_pkg::BIT_DEVS-1:0] devBits,
    output logic [lfse_pkg::ADDR_W-1:0] stepPc,
    output logic running,
    output logic opError,
    output logic scanDone
);
    // program store, one instruction word per step
    logic [15:0] progMem [lfse_pkg::PROG_DEPTH];
    lfse_pkg::lfse_regs_t r_reg;
    lfse_pkg::lfse_regs_t r_next;

    // current instruction fields
    logic [15:0] instr;
    logic [3:0] op;
    logic [3:0] aux;
    logic [7:0] opnd;
    logic regionEn;
    logic [2:0] tIdx;
    // timer base wraps in this cycle
    logic tickHit;
    // local copies of package widths, used as size casts
    localparam int TICK_W = lfse_pkg::TICK_W;
    localparam int ADDR_W = lfse_pkg::ADDR_W;
    localparam int PV_W = lfse_pkg::PV_W;

    assign instr = progMem[r_reg.pc];
    assign op = instr[lfse_pkg::OP_POS +: 4];
    assign aux = instr[lfse_pkg::AUX_POS +: 4];
    assign opnd = instr[7:0];
    assign tIdx = opnd[2:0];
    assign tickHit = (r_reg.tickCnt == TICK_W'(TICK_CYCLES - 1));
    // region is enabled only if every open level has its condition on
    assign regionEn = &(~r_reg.gateOpen | r_reg.gateOn);

    // contact read over bit devices, pins, timer and counter contacts
    function automatic logic readContact(input lfse_pkg::lfse_regs_t s, input logic [7:0] idx);
        logic v;
        v = 1'b0;
        if (idx < 8'(lfse_pkg::X_PINS)) begin
            v = s.xSync2[idx[3:0]];
        end else if (idx < lfse_pkg::TMR_BASE) begin
            v = s.bits[idx[5:0]];
        end else if (idx < lfse_pkg::CNT_BASE) begin
            v = s.tmrDone[idx[2:0]];
        end else if (idx < lfse_pkg::DEV_LIMIT) begin
            v = s.cntDone[idx[2:0]];
        end
        return v;
    endfunction

    // program store writes; loading restarts the end-marker check
    always_ff @(posedge clk) begin
        if (progWe) begin
            progMem[progAddr] <= progData;
        end
    end

    // next-state logic for the whole engine
    always_comb begin
        r_next = r_reg;
        r_next.scanDone = 1'b0;
        // pins pass two flops before any logic reads them
        r_next.xSync1 = xPins;
        r_next.xSync2 = r_reg.xSync1;
        // free-running timer base, remembered until the next scan starts
        if (tickHit) begin
            r_next.tickCnt = '0;
            r_next.tickSeen = 1'b1;
        end else begin
            r_next.tickCnt = r_reg.tickCnt + 1'b1;
        end
        case (r_reg.state)
            lfse_pkg::ST_CHECK: begin
                if (op == lfse_pkg::OP_PROG_END) begin
                    r_next.state = runEn ? lfse_pkg::ST_RUN : lfse_pkg::ST_CHECK;
                    r_next.pc = runEn ? lfse_pkg::PC_RESET : r_reg.pc;
                end else if (r_reg.pc == ADDR_W'(lfse_pkg::PROG_DEPTH - 1)) begin
                    r_next.state = lfse_pkg::ST_ERROR;
                    r_next.opError = 1'b1;
                end else begin
                    r_next.pc = r_reg.pc + 1'b1;
                end
            end
            lfse_pkg::ST_RUN: begin
                // one instruction per clock, gated or not
                // constant step time
                r_next.pc = r_reg.pc + 1'b1;
                case (op)
                    lfse_pkg::OP_LOAD: begin
                        r_next.acc = readContact(r_reg, opnd);
                    end
                    lfse_pkg::OP_LOAD_INV: begin
                        r_next.acc = ~readContact(r_reg, opnd);
                    end
                    lfse_pkg::OP_AND: begin
                        r_next.acc = r_reg.acc & readContact(r_reg, opnd);
                    end
                    lfse_pkg::OP_OR: begin
                        r_next.acc = r_reg.acc | readContact(r_reg, opnd);
                    end
                    lfse_pkg::OP_COIL: begin
                        if (opnd < lfse_pkg::TMR_BASE) begin
                            r_next.bits[opnd[5:0]] = r_reg.acc & regionEn;
                        end
                    end
                    lfse_pkg::OP_SET: begin
                        if (regionEn && r_reg.acc && opnd < lfse_pkg::TMR_BASE) begin
                            r_next.bits[opnd[5:0]] = 1'b1;
                        end
                    end
                    lfse_pkg::OP_CLEAR: begin
                        if (regionEn && r_reg.acc) begin
                            if (opnd < lfse_pkg::TMR_BASE) begin
                                r_next.bits[opnd[5:0]] = 1'b0;
                            end else if (opnd < lfse_pkg::CNT_BASE) begin
                                r_next.tmrPv[tIdx] = '0;
                                r_next.tmrCoil[tIdx] = 1'b0;
                                r_next.tmrDone[tIdx] = 1'b0;
                            end else if (opnd < lfse_pkg::DEV_LIMIT) begin
                                r_next.cntPv[tIdx] = '0;
                                r_next.cntCoil[tIdx] = 1'b0;
                                r_next.cntDone[tIdx] = 1'b0;
                            end
                        end
                    end
                    lfse_pkg::OP_SHIFT, lfse_pkg::OP_SHIFT_PULSED: begin
                        // the pulsed form fires only on a rising condition at this step
                        r_next.pulseMem[r_reg.pc] = r_reg.acc;
                        if (regionEn && r_reg.acc && opnd < lfse_pkg::TMR_BASE &&
                            (op == lfse_pkg::OP_SHIFT || !r_reg.pulseMem[r_reg.pc])) begin
                            r_next.bits[opnd[5:0]] = (opnd == 8'h00) ? 1'b0 : r_reg.bits[opnd[5:0] - 6'h01];
                            if (opnd != 8'h00) begin
                                r_next.bits[opnd[5:0] - 6'h01] = 1'b0;
                            end
                        end
                    end
                    lfse_pkg::OP_GATE_OPEN: begin
                        // level reuse just overwrites its state
                        if (aux < 4'(lfse_pkg::NEST_LEVELS)) begin
                            r_next.gateOpen[aux] = 1'b1;
                            r_next.gateOn[aux] = r_reg.acc & regionEn;
                            if (opnd < lfse_pkg::TMR_BASE) begin
                                r_next.bits[opnd[5:0]] = r_reg.acc & regionEn;
                            end
                        end
                    end
                    lfse_pkg::OP_GATE_CLOSE: begin
                        // close this level and every deeper one
                        for (int i = 0; i < lfse_pkg::NEST_LEVELS; i++) begin
                            if (4'(i) >= aux) begin
                                r_next.gateOpen[i] = 1'b0;
                                r_next.gateOn[i] = 1'b0;
                            end
                        end
                    end
                    lfse_pkg::OP_TIMER: begin
                        if (regionEn) begin
                            r_next.tmrCoil[tIdx] = r_reg.acc;
                            if (r_reg.acc) begin
                                // setting zero never times up
                                if (r_reg.tickScan && !r_reg.tmrDone[tIdx] && aux != 4'h0) begin
                                    r_next.tmrPv[tIdx] = r_reg.tmrPv[tIdx] + 1'b1;
                                    r_next.tmrDone[tIdx] = (r_reg.tmrPv[tIdx] + 1'b1) >= PV_W'(aux);
                                end
                            end else if (!opnd[lfse_pkg::RETAIN_BIT]) begin
                                r_next.tmrPv[tIdx] = '0;
                                r_next.tmrDone[tIdx] = 1'b0;
                            end
                        end else if (opnd[lfse_pkg::RETAIN_BIT]) begin
                            r_next.tmrCoil[tIdx] = 1'b0;
                        end else begin
                            r_next.tmrCoil[tIdx] = 1'b0;
                            r_next.tmrPv[tIdx] = '0;
                            r_next.tmrDone[tIdx] = 1'b0;
                        end
                    end
                    lfse_pkg::OP_COUNTER: begin
                        // disabled counter coil off, value kept
                        r_next.cntCoil[tIdx] = r_reg.acc & regionEn;
                        if (regionEn && r_reg.acc && !r_reg.cntCoil[tIdx] && !r_reg.cntDone[tIdx]) begin
                            r_next.cntPv[tIdx] = r_reg.cntPv[tIdx] + 1'b1;
                            // a setting of zero behaves as one
                            r_next.cntDone[tIdx] = (r_reg.cntPv[tIdx] + 1'b1) >=
                                ((aux == 4'h0) ? PV_W'(1) : PV_W'(aux));
                        end
                    end
                    lfse_pkg::OP_MAIN_TERM, lfse_pkg::OP_PROG_END: begin
                        r_next.pc = lfse_pkg::PC_RESET;
                        r_next.scanDone = 1'b1;
                        r_next.gateOpen = '0;
                        r_next.gateOn = '0;
                        r_next.tickScan = r_reg.tickSeen;
                        // a tick on the scan-end cycle itself is kept for the next scan, never lost
                        r_next.tickSeen = tickHit;
                        if (!runEn) begin
                            r_next.state = lfse_pkg::ST_CHECK;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            lfse_pkg::ST_ERROR: begin
                r_next.opError = 1'b1;
            end
            default: begin
                r_next.state = lfse_pkg::ST_CHECK;
            end
        endcase
        // any program write restarts the check from step zero
        if (progWe) begin
            r_next.state = lfse_pkg::ST_CHECK;
            r_next.pc = lfse_pkg::PC_RESET;
            r_next.opError = 1'b0;
            r_next.gateOpen = '0;
            r_next.gateOn = '0;
        end
        // run flag follows the state that will be registered
        r_next.runFlag = (r_next.state == lfse_pkg::ST_RUN);
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from state flops
    assign devBits = r_reg.bits;
    assign stepPc = r_reg.pc;
    assign running = r_reg.runFlag;
    assign opError = r_reg.opError;
    assign scanDone = r_reg.scanDone;
endmodule
`default_nettype wire

// [sim/lfse_ladder_flow_shift_engine_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module lfse_checker #(
    parameter int TICK_CYCLES = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // load and run requests
    input wire logic progWe,
    input wire logic runEn,
    // engine status
    input wire logic [lfse_pkg::ADDR_W-1:0] stepPc,
    input wire logic running,
    input wire logic opError,
    input wire logic scanDone
);
    // one domain, so one clock and one disable for all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_err_blocks_run: assert property (opError |-> !running) else $error("running while in error");
    a_err_holds_level: assert property (opError && !progWe |=> opError) else $error("error dropped");
    a_load_clears_err: assert property (progWe |=> !opError && !running) else $error("load did not restart");
    a_err_full_check: assert property ($rose(opError) |-> $past(stepPc) == 8'hff) else $error("early error");
    a_scan_wraps_zero: assert property (scanDone |-> stepPc == 8'h00) else $error("no wrap to step zero");
    a_run_starts_zero: assert property ($rose(running) |-> stepPc == 8'h00) else $error("run not at zero");
    a_step_by_one: assert property (running && $past(running) && !scanDone && !$past(progWe)
        |-> stepPc == $past(stepPc) + 8'h01) else $error("step skipped");
    a_run_ends_scan: assert property ($fell(running) |-> scanDone || $past(progWe)) else $error("run cut");
    a_run_needs_en: assert property ($rose(running) |-> $past(runEn)) else $error("run without enable");

    // main scenarios reached
    c_scan_end: cover property (scanDone);
    c_error_seen: cover property ($rose(opError));
    c_long_scan: cover property (running && stepPc == 8'h0b);
endmodule

bind lfse_ladder_flow_shift_engine lfse_checker #(.TICK_CYCLES(TICK_CYCLES)) lfse_checker_inst (
    .clk(clk), .arst_n(arst_n), .progWe(progWe), .runEn(runEn), .stepPc(stepPc),
    .running(running), .opError(opError), .scanDone(scanDone)
);
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    // expected outcome of one scan: watched devices and scan length
    typedef struct packed {
        logic [63:0] mask;
        logic [63:0] val;
        logic [7:0] len;
    } lfse_note_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic progWe = 1'b0;
    logic [7:0] progAddr = 8'h00;
    logic [15:0] progData = 16'h0000;
    logic runEn = 1'b0;
    logic [15:0] xPins = 16'h0000;
    logic [63:0] devBits;
    logic [7:0] stepPc;
    logic running;
    logic opError;
    logic scanDone;
    int nMismatch = 0;
    int checksDone = 0;
    lfse_note_t notes[$]; // one note per requested scan
    logic [7:0] runCnt = 8'h00; // running cycles of current scan

    always #2.5 clk = ~clk;

    // short timer tick keeps the run brief
    lfse_ladder_flow_shift_engine #(.TICK_CYCLES(20)) lfse_ladder_flow_shift_engine_inst (
        .clk(clk), .arst_n(arst_n), .progWe(progWe), .progAddr(progAddr), .progData(progData),
        .runEn(runEn), .xPins(xPins), .devBits(devBits), .stepPc(stepPc), .running(running),
        .opError(opError), .scanDone(scanDone)
    );

    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        if (nMismatch == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // scan observer: values sampled at the edge are those of the ending cycle
    always @(posedge clk) begin : observer
        lfse_note_t n;
        if (scanDone === 1'b1) begin
            if (notes.size() == 0) begin
                cmp("unexpected scan", 64'h0, 64'h1);
            end else begin
                n = notes.pop_front();
                cmp("devices", n.val & n.mask, devBits & n.mask);
                cmp("scan length", {56'h0, n.len}, {56'h0, runCnt});
            end
            runCnt <= 8'h00;
        end else if (running === 1'b1) begin
            runCnt <= runCnt + 8'h01;
        end
    end

    // one program word; strobe stays up between back-to-back words
    task automatic wr(input logic [7:0] a, input logic [3:0] op, input logic [7:0] opd, input logic [3:0] aux = 4'h0);
        progWe <= 1'b1;
        progAddr <= a;
        progData <= {op, aux, opd};
        @(posedge clk);
    endtask

    task automatic wrDone();
        progWe <= 1'b0;
        @(posedge clk);
    endtask

    // exactly one scan: enable drops before the scan can end
    task automatic scan(input logic [15:0] pins, input logic [63:0] mask, input logic [63:0] val, input logic [7:0] len);
        int k;
        xPins <= pins;
        notes.push_back('{mask, val, len});
        repeat (4) @(posedge clk);
        runEn <= 1'b1;
        k = 0;
        do begin @(posedge clk); #1; k++; end while (running !== 1'b1 && k < 600);
        cmp("run started", 64'h1, {63'h0, running});
        @(posedge clk);
        runEn <= 1'b0;
        k = 0;
        do begin @(posedge clk); #1; k++; end while (running !== 1'b0 && k < 300);
        cmp("scan finished", 64'h0, {63'h0, running});
        @(posedge clk);
    endtask

    initial begin
        logic [63:0] m;
        logic g;
        int i;
        logic gp;
        int c;
        void'($urandom(32'h14d77619));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // whole store gets no-ops so nothing reads unknown
        for (i = 0; i < 256; i++) wr(i[7:0], lfse_pkg::OP_NOP, 8'h00);
        wr(0, lfse_pkg::OP_LOAD, 8'h00);
        wr(1, lfse_pkg::OP_SHIFT, 8'h23);
        wr(2, lfse_pkg::OP_SHIFT, 8'h22);
        wr(3, lfse_pkg::OP_SHIFT, 8'h21);
        wr(4, lfse_pkg::OP_LOAD, 8'h01);
        wr(5, lfse_pkg::OP_SET, 8'h20);
        wr(6, lfse_pkg::OP_PROG_END, 8'h00);
        wrDone();
        m = '0;
        for (i = 0; i < 8; i++) begin
            g = (i == 0) ? 1'b1 : 1'($urandom);
            m[35:32] = {m[34:32], g};
            scan((16'($urandom) & 16'hfffc) | {14'h0, g, 1'b1}, 64'h0000_000f_0000_0000, m, 8'd7);
        end
        // gated regions, nested, closed together by the lowest level
        // open ascending, close lowest
        wr(0, lfse_pkg::OP_LOAD, 8'h02);
        wr(1, lfse_pkg::OP_GATE_OPEN, 8'h30, 4'h0);
        wr(2, lfse_pkg::OP_LOAD, 8'h03);
        wr(3, lfse_pkg::OP_COIL, 8'h31);
        wr(4, lfse_pkg::OP_SET, 8'h32);
        wr(5, lfse_pkg::OP_GATE_OPEN, 8'h33, 4'h1);
        wr(6, lfse_pkg::OP_LOAD, 8'h03);
        wr(7, lfse_pkg::OP_COIL, 8'h34);
        wr(8, lfse_pkg::OP_GATE_CLOSE, 8'h00, 4'h0);
        wr(9, lfse_pkg::OP_LOAD, 8'h03);
        wr(10, lfse_pkg::OP_COIL, 8'h35);
        wr(11, lfse_pkg::OP_PROG_END, 8'h00);
        wrDone();
        for (i = 0; i < 8; i++) begin
            g = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
            m[53:48] = {1'b1, g, g, m[50] | g, g, g};
            scan((16'($urandom) & 16'hfff3) | {12'h0, 1'b1, g, 2'b00}, 64'h003f_0000_0000_0000, m, 8'd12);
        end
        // terminate at step two: later coil never runs
        wr(0, lfse_pkg::OP_LOAD, 8'h03);
        wr(1, lfse_pkg::OP_COIL, 8'h36);
        wr(2, lfse_pkg::OP_MAIN_TERM, 8'h00);
        wr(3, lfse_pkg::OP_LOAD, 8'h03);
        wr(4, lfse_pkg::OP_COIL, 8'h37);
        wrDone();
        scan(16'h0008, 64'h00c0_0000_0000_0000, 64'h0040_0000_0000_0000, 8'd3);
        wr(0, lfse_pkg::OP_LOAD, 8'h02);
        wr(1, lfse_pkg::OP_GATE_OPEN, 8'h39, 4'h0);
        wr(2, lfse_pkg::OP_LOAD, 8'h03);
        wr(3, lfse_pkg::OP_TIMER, 8'h00, 4'h1);
        wr(4, lfse_pkg::OP_TIMER, 8'h81, 4'h1);
        wr(5, lfse_pkg::OP_COUNTER, 8'h00, 4'h2);
        wr(6, lfse_pkg::OP_GATE_CLOSE, 8'h00, 4'h0);
        wr(7, lfse_pkg::OP_LOAD, 8'h40);
        wr(8, lfse_pkg::OP_COIL, 8'h3a);
        wr(9, lfse_pkg::OP_LOAD, 8'h41);
        wr(10, lfse_pkg::OP_COIL, 8'h3b);
        wr(11, lfse_pkg::OP_LOAD, 8'h48);
        wr(12, lfse_pkg::OP_COIL, 8'h3c);
        // pulsed shift moves only on a rising condition
        wr(13, lfse_pkg::OP_LOAD, 8'h02);
        wr(14, lfse_pkg::OP_SHIFT_PULSED, 8'h3e);
        wr(15, lfse_pkg::OP_LOAD, 8'h03);
        wr(16, lfse_pkg::OP_SET, 8'h3d);
        wr(17, lfse_pkg::OP_PROG_END, 8'h00);
        wrDone();
        // scans lie more than TICK_CYCLES apart, so a one-tick setting is reached in any enabled scan
        c = 0;
        gp = 1'b0;
        for (i = 0; i < 8; i++) begin
            g = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
            c = c + ((g && !gp) ? 1 : 0);
            m[62:57] = {m[62] | (g & ~gp & (i > 0)), 1'b1, c >= 2, m[59] | g, g, g};
            gp = g;
            scan((16'($urandom) & 16'hfff3) | {12'h0, 1'b1, g, 2'b00}, 64'h7e00_0000_0000_0000, m, 8'd18);
        end
        // no end marker left anywhere: error, and no run
        wr(17, lfse_pkg::OP_NOP, 8'h00);
        wrDone();
        runEn <= 1'b1;
        repeat (400) @(posedge clk);
        cmp("error flag", 64'h1, {63'h0, opError});
        cmp("running", 64'h0, {63'h0, running});
        runEn <= 1'b0;
        wr(17, lfse_pkg::OP_PROG_END, 8'h00);
        wrDone();
        #1;
        cmp("error cleared", 64'h0, {63'h0, opError});
        cmp("notes left", 64'h0, 64'(notes.size()));
        summarize();
    end

    // hang guard, well beyond the expected run
    initial begin
        #(30000 * 5);
        nMismatch++;
        summarize();
    end
endmodule
`default_nettype wire
